// file: ipg_pkg.sv
// Register map, field layout and constants of the input gain control block
package ipg_pkg;
    // Register addresses as seen on the control port
    localparam logic [7:0] IPG_LEFT_GAIN_ADDR = 8'h2c;
    localparam logic [7:0] IPG_RIGHT_GAIN_ADDR = 8'h2d;
    localparam logic [7:0] IPG_LEFT_CFG_ADDR = 8'h2e;
    localparam logic [7:0] IPG_RIGHT_CFG_ADDR = 8'h2f;

    // Field positions
    localparam int IPG_VOL_LSB = 0;
    localparam int IPG_VOL_W = 5;
    localparam int IPG_MUTE_BIT = 7;
    localparam int IPG_MODE_LSB = 0;
    localparam int IPG_SELP_LSB = 2;
    localparam int IPG_SELN_LSB = 4;
    localparam int IPG_CM_BIT = 6;

    // Reset values and writable bits
    localparam logic [15:0] IPG_GAIN_RST = 16'h0085;
    localparam logic [15:0] IPG_CFG_RST = 16'h0044;
    localparam logic [15:0] IPG_GAIN_MASK = 16'h009f;
    localparam logic [15:0] IPG_CFG_MASK = 16'h007f;
    localparam logic [15:0] IPG_RD_IDLE = 16'h0000;

    // Gain values in tenths of a dB, two's complement, and the volume codes they belong to
    localparam logic signed [9:0] IPG_SE_BOOST = 10'h03c;
    localparam logic signed [9:0] IPG_MIC_MAX = 10'h12c;
    localparam logic [4:0] IPG_MIC_TOP_CODE = 5'h07;
    localparam logic [4:0] IPG_VOL_UNITY = 5'h05;
    localparam logic [4:0] IPG_VOL_TOP = 5'h1f;
    localparam logic signed [9:0] IPG_LINE_TOP = 10'h11b;
    localparam logic signed [9:0] IPG_GAIN_ZERO = 10'h000;

    typedef enum logic [1:0] {
        IPG_SINGLE = 2'b00,
        IPG_DIFF_LINE = 2'b01,
        IPG_DIFF_MIC = 2'b10,
        IPG_MODE_RSVD = 2'b11
    } ipg_mode_t;
endpackage

// file: ipg_gain_decode.sv
// Maps a volume code and input mode onto the amplifier gain
`timescale 1ns/1ns
module ipg_gain_decode
    import ipg_pkg::*;
(
    // Settings
    input wire logic [4:0] code,
    input wire ipg_pkg::ipg_mode_t mode,
    // Decoded gain
    output logic signed [9:0] gain_db10,
    output logic code_bad
);
    logic signed [9:0] line_gain;
    logic signed [9:0] mic_gain;

    // Non-linear line/single-ended table, unity at code 5
    always_comb begin
        case (code)
            5'h00: line_gain = 10'h3f1;
            5'h01: line_gain = 10'h3f3;
            5'h02: line_gain = 10'h3f6;
            5'h03: line_gain = 10'h3f9;
            5'h04: line_gain = 10'h3fd;
            5'h05: line_gain = 10'h000;
            5'h06: line_gain = 10'h003;
            5'h07: line_gain = 10'h007;
            5'h08: line_gain = 10'h00a;
            5'h09: line_gain = 10'h00e;
            5'h0a: line_gain = 10'h012;
            5'h0b: line_gain = 10'h017;
            5'h0c: line_gain = 10'h01b;
            5'h0d: line_gain = 10'h020;
            5'h0e: line_gain = 10'h025;
            5'h0f: line_gain = 10'h02a;
            5'h10: line_gain = 10'h030;
            5'h11: line_gain = 10'h036;
            5'h12: line_gain = 10'h03c;
            5'h13: line_gain = 10'h043;
            5'h14: line_gain = 10'h04b;
            5'h15: line_gain = 10'h053;
            5'h16: line_gain = 10'h05c;
            5'h17: line_gain = 10'h066;
            5'h18: line_gain = 10'h072;
            5'h19: line_gain = 10'h07f;
            5'h1a: line_gain = 10'h08f;
            5'h1b: line_gain = 10'h0a2;
            5'h1c: line_gain = 10'h0c0;
            5'h1d: line_gain = 10'h0df;
            5'h1e: line_gain = 10'h0fc;
            default: line_gain = 10'h11b;
        endcase
    end

    // Microphone mode: 3 dB steps from code 1, saturating at code 7
    always_comb begin
        case (code)
            5'h01: mic_gain = 10'h078;
            5'h02: mic_gain = 10'h096;
            5'h03: mic_gain = 10'h0b4;
            5'h04: mic_gain = 10'h0d2;
            5'h05: mic_gain = 10'h0f0;
            5'h06: mic_gain = 10'h10e;
            5'h00: mic_gain = 10'h078;
            default: mic_gain = IPG_MIC_MAX;
        endcase
    end

    always_comb begin
        code_bad = 1'b0;
        case (mode)
            IPG_SINGLE: gain_db10 = line_gain + IPG_SE_BOOST;
            IPG_DIFF_LINE: gain_db10 = line_gain;
            IPG_DIFF_MIC: begin
                gain_db10 = mic_gain;
                // Code 0 has no valid gain here; flagged, not fixed up
                code_bad = (code == 5'h00);
            end
            default: gain_db10 = line_gain;
        endcase
    end
endmodule

// file: ipg_gain_ctrl.sv
// Register bank and decoded settings for the stereo input amplifiers
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
module ipg_gain_ctrl (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rd_data,
    // Left channel settings
    output logic [4:0] left_gain_code,
    output logic signed [9:0] left_gain_db10,
    output logic left_silence,
    output logic left_common_reject_on,
    output logic left_code_bad,
    // Right channel settings
    output logic [4:0] right_gain_code,
    output logic signed [9:0] right_gain_db10,
    output logic right_silence,
    output logic right_common_reject_on,
    output logic right_code_bad
);
    import ipg_pkg::*;

    logic [15:0] gain_reg [2];
    logic [15:0] cfg_reg [2];
    logic [15:0] next_rd_data;
    logic [4:0] code_q [2];
    logic signed [9:0] db_q [2];
    logic silence_q [2];
    logic cm_q [2];
    logic bad_q [2];

    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        logic [7:0] gain_addr;
        logic [7:0] cfg_addr;
        logic [15:0] next_gain;
        logic [15:0] next_cfg;
        logic [4:0] code;
        ipg_mode_t mode;
        logic signed [9:0] dec_gain;
        logic dec_bad;
        logic next_cm;

        assign gain_addr = (ch == 0) ? IPG_LEFT_GAIN_ADDR
            : IPG_RIGHT_GAIN_ADDR;
        assign cfg_addr = (ch == 0) ? IPG_LEFT_CFG_ADDR : IPG_RIGHT_CFG_ADDR;
        assign code = gain_reg[ch][IPG_VOL_LSB +: IPG_VOL_W];
        assign mode = ipg_mode_t'(cfg_reg[ch][IPG_MODE_LSB +: 2]);

        // Each register is decoded on its own address only
        always_comb begin
            next_gain = gain_reg[ch];
            next_cfg = cfg_reg[ch];
            if (wr_en && addr == gain_addr) begin
                next_gain = wr_data & IPG_GAIN_MASK;
            end
            if (wr_en && addr == cfg_addr) begin
                next_cfg = wr_data & IPG_CFG_MASK;
            end
        end

        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                gain_reg[ch] <= IPG_GAIN_RST;
                cfg_reg[ch] <= IPG_CFG_RST;
            end else begin
                gain_reg[ch] <= next_gain;
                cfg_reg[ch] <= next_cfg;
            end
        end

        ipg_gain_decode u_dec (
            .code(code),
            .mode(mode),
            .gain_db10(dec_gain),
            .code_bad(dec_bad)
        );

        // Bit is kept in any mode but only acts in line mode
        always_comb begin
            next_cm = cfg_reg[ch][IPG_CM_BIT]
                && (mode == IPG_DIFF_LINE);
        end

        // Settings follow the registers one edge later, glitch free
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                code_q[ch] <= IPG_GAIN_RST[IPG_VOL_LSB +: IPG_VOL_W];
                db_q[ch] <= IPG_SE_BOOST;
                silence_q[ch] <= 1'b1;
                cm_q[ch] <= 1'b0;
                bad_q[ch] <= 1'b0;
            end else begin
                code_q[ch] <= code;
                db_q[ch] <= dec_gain;
                silence_q[ch] <= gain_reg[ch][IPG_MUTE_BIT];
                cm_q[ch] <= next_cm;
                bad_q[ch] <= dec_bad;
            end
        end
    end

    // Read path: unmapped addresses read zero
    always_comb begin
        next_rd_data = IPG_RD_IDLE;
        if (rd_en) begin
            case (addr)
                IPG_LEFT_GAIN_ADDR: next_rd_data = gain_reg[0];
                IPG_RIGHT_GAIN_ADDR: next_rd_data = gain_reg[1];
                IPG_LEFT_CFG_ADDR: next_rd_data = cfg_reg[0];
                IPG_RIGHT_CFG_ADDR: next_rd_data = cfg_reg[1];
                default: next_rd_data = IPG_RD_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_data <= IPG_RD_IDLE;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    assign left_gain_code = code_q[0];
    assign left_gain_db10 = db_q[0];
    assign left_silence = silence_q[0];
    assign left_common_reject_on = cm_q[0];
    assign left_code_bad = bad_q[0];
    assign right_gain_code = code_q[1];
    assign right_gain_db10 = db_q[1];
    assign right_silence = silence_q[1];
    assign right_common_reject_on = cm_q[1];
    assign right_code_bad = bad_q[1];

    left_vol_follow_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_en && addr == IPG_LEFT_GAIN_ADDR)
            ##1 !(wr_en && addr == IPG_LEFT_GAIN_ADDR)
            |=> left_gain_code == $past(wr_data[4:0], 2))
        else $error("left volume code not applied");

    right_vol_follow_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_en && addr == IPG_RIGHT_GAIN_ADDR)
            ##1 !(wr_en && addr == IPG_RIGHT_GAIN_ADDR)
            |=> right_gain_code == $past(wr_data[4:0], 2))
        else $error("right volume code not applied");

    mute_follow_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_en && addr == IPG_LEFT_GAIN_ADDR)
            ##1 !(wr_en && addr == IPG_LEFT_GAIN_ADDR)
            |=> left_silence == $past(wr_data[IPG_MUTE_BIT], 2))
        else $error("left mute not applied");

    channel_isolation_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_en && (addr == IPG_LEFT_GAIN_ADDR || addr == IPG_LEFT_CFG_ADDR))
            |=> ##1 $stable(right_gain_db10) && $stable(right_silence)
            && $stable(right_common_reject_on))
        else $error("left write disturbed right channel");

    line_unity_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (g_ch[0].mode == IPG_DIFF_LINE && g_ch[0].code == IPG_VOL_UNITY)
            |=> left_gain_db10 == IPG_GAIN_ZERO)
        else $error("line mode unity code not 0 dB");

    line_top_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (g_ch[1].mode == IPG_DIFF_LINE && g_ch[1].code == IPG_VOL_TOP)
            |=> right_gain_db10 == IPG_LINE_TOP)
        else $error("line mode top code wrong");

    mic_saturate_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (g_ch[0].mode == IPG_DIFF_MIC && g_ch[0].code >= IPG_MIC_TOP_CODE)
            |=> left_gain_db10 == IPG_MIC_MAX)
        else $error("mic gain not saturated");

    single_boost_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (g_ch[1].mode == IPG_SINGLE && g_ch[1].code == IPG_VOL_UNITY)
            |=> right_gain_db10 == IPG_SE_BOOST)
        else $error("single-ended boost missing");

    cm_gate_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> left_common_reject_on == ($past(cfg_reg[0][IPG_CM_BIT])
            && $past(cfg_reg[0][1:0]) == IPG_DIFF_LINE))
        else $error("common-mode enable not gated by mode");

    mode_readback_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (rd_en && addr == IPG_RIGHT_CFG_ADDR) |=>
            rd_data[1:0] == $past(cfg_reg[1][1:0]))
        else $error("mode field readback wrong");

    right_mute_follow_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_en && addr == IPG_RIGHT_GAIN_ADDR)
            ##1 !(wr_en && addr == IPG_RIGHT_GAIN_ADDR)
            |=> right_silence == $past(wr_data[IPG_MUTE_BIT], 2))
        else $error("right mute not applied");

    right_isolation_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_en && (addr == IPG_RIGHT_GAIN_ADDR || addr == IPG_RIGHT_CFG_ADDR))
            |=> ##1 $stable(left_gain_db10) && $stable(left_silence)
            && $stable(left_common_reject_on) && $stable(left_gain_code))
        else $error("right write disturbed left channel");

    left_mic_low_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (g_ch[0].mode == IPG_DIFF_MIC && g_ch[0].code == 5'h01)
            |=> left_gain_db10 == 10'h078)
        else $error("mic mode lowest code not 12 dB");

    right_mic_step_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (g_ch[1].mode == IPG_DIFF_MIC && g_ch[1].code == 5'h04)
            |=> right_gain_db10 == 10'h0d2)
        else $error("mic mode step wrong");

    left_line_bottom_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (g_ch[0].mode == IPG_DIFF_LINE && g_ch[0].code == 5'h00)
            |=> left_gain_db10 == 10'h3f1)
        else $error("line mode bottom code wrong");

    left_se_boost_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (g_ch[0].mode == IPG_SINGLE && g_ch[0].code == IPG_VOL_UNITY)
            |=> left_gain_db10 == IPG_SE_BOOST)
        else $error("left single-ended boost missing");

    right_line_unity_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (g_ch[1].mode == IPG_DIFF_LINE && g_ch[1].code == IPG_VOL_UNITY)
            |=> right_gain_db10 == IPG_GAIN_ZERO)
        else $error("right line mode unity code not 0 dB");

    right_cm_gate_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> right_common_reject_on == ($past(cfg_reg[1][IPG_CM_BIT])
            && $past(cfg_reg[1][1:0]) == IPG_DIFF_LINE))
        else $error("right common-mode enable not gated by mode");

    left_mode_readback_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (rd_en && addr == IPG_LEFT_CFG_ADDR) |=>
            rd_data[1:0] == $past(cfg_reg[0][1:0]))
        else $error("left mode field readback wrong");

    gain_mask_read_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (rd_en && addr == IPG_LEFT_GAIN_ADDR) |=>
            rd_data[15:8] == 8'h00 && rd_data[6:5] == 2'b00)
        else $error("unused gain bits read back set");

    left_bad_flag_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (g_ch[0].mode == IPG_DIFF_MIC && g_ch[0].code == 5'h00)
            |=> left_code_bad)
        else $error("left illegal mic code not flagged");

    right_bad_flag_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (g_ch[1].mode == IPG_DIFF_MIC && g_ch[1].code == 5'h00)
            |=> right_code_bad)
        else $error("right illegal mic code not flagged");

    // Reset is synchronous, so the outputs settle one edge into it
    reset_outputs_a: assert property (
        @(posedge ref_clk)
        !rst_n |=> left_silence && right_silence
            && left_gain_code == IPG_VOL_UNITY
            && right_gain_code == IPG_VOL_UNITY)
        else $error("outputs not at reset values");

    reset_config_a: assert property (
        @(posedge ref_clk)
        !rst_n |=> cfg_reg[0][IPG_CM_BIT] && cfg_reg[1][IPG_CM_BIT]
            && g_ch[0].mode == IPG_SINGLE && g_ch[1].mode == IPG_SINGLE)
        else $error("config registers not at reset values");
endmodule

// file: ipg_gain_ctrl_tb.sv
// Self-checking testbench of the input gain control register bank
`timescale 1ns/1ns
module ipg_gain_ctrl_tb;
    import ipg_pkg::*;
    logic ref_clk, rst_n, wr_en, rd_en;
    logic [7:0] addr;
    logic [15:0] wr_data, rd_data, m[4];
    logic [4:0] oc[2];
    logic signed [9:0] og[2];
    logic os[2], ocm[2], obad[2];
    logic [31:0] lfsr;
    int miscompares, num_checks, cycles;
    // Line and single-ended volume table, tenths of a dB
    int line[32] = '{-15, -13, -10, -7, -3, 0, 3, 7, 10, 14, 18, 23, 27, 32,
        37, 42, 48, 54, 60, 67, 75, 83, 92, 102, 114, 127, 143, 162, 192, 223,
        252, 283};

    ipg_gain_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .left_gain_code(oc[0]), .left_gain_db10(og[0]), .left_silence(os[0]),
        .left_common_reject_on(ocm[0]), .left_code_bad(obad[0]),
        .right_gain_code(oc[1]), .right_gain_db10(og[1]),
        .right_silence(os[1]), .right_common_reject_on(ocm[1]),
        .right_code_bad(obad[1]));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic signed [9:0] exp_gain(input logic [4:0] c,
        input logic [1:0] md);
        int g;
        if (md == 2'b10)
            g = (c == 0) ? 120 : ((c >= 7) ? 300 : 120 + 30 * (int'(c) - 1));
        else
            g = line[c] + ((md == 2'b00) ? 60 : 0);
        return 10'(g);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a[7:2] == 6'h0b;
    endfunction

    task automatic check(input string nm, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Decoded outputs show one edge after the register takes the write
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        if (mapped(a))
            m[a[1:0]] = d & (a[1] ? IPG_CFG_MASK : IPG_GAIN_MASK);
        @(posedge ref_clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        logic [15:0] e;
        e = mapped(a) ? m[a[1:0]] : 16'h0000;
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        check("rd_data", rd_data, e);
        @(posedge ref_clk);
        #1;
        check("rd_idle", rd_data, 16'h0000);
    endtask

    task automatic chk_ch(input int c);
        logic [4:0] g;
        logic [1:0] md;
        g = m[c][4:0];
        md = m[c + 2][1:0];
        check("gain_code", {11'h000, oc[c]},
            {11'h000, g});
        check("gain_db10", 16'(og[c]),
            16'(exp_gain(g, md)));
        check("silence", {15'h0000, os[c]},
            {15'h0000, m[c][7]});
        check("cm_on", {15'h0000, ocm[c]},
            {15'h0000, m[c + 2][6] && md == 2'b01});
        check("code_bad", {15'h0000, obad[c]},
            {15'h0000, md == 2'b10 && g == 5'h00});
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        m = '{IPG_GAIN_RST, IPG_GAIN_RST, IPG_CFG_RST, IPG_CFG_RST};
        #1;
        chk_ch(0);
        chk_ch(1);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    initial begin
        rst_n = 1'b0;
        addr = 8'h00;
        wr_data = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        lfsr = 32'h0000_eebd;
        do_reset();
        for (int i = 0; i < 4; i++)
            rd(8'h2c + 8'(i));
        rd(8'h2b);
        rd(8'h30);
        $display("test reset values done");
        // Every mode and code per channel, muted while the code moves;
        // code 0 in mic mode is a deliberate corner to see the flag
        for (int c = 0; c < 2; c++)
            for (int md = 0; md < 4; md++)
                for (int v = 0; v < 32; v++) begin
                    wr(8'h2e + 8'(c), 16'h0040 | 16'(md));
                    wr(8'h2c + 8'(c), 16'h0080 | 16'(v));
                    chk_ch(0);
                    chk_ch(1);
                end
        $display("test gain sweep done");
        for (int i = 0; i < 300; i++) begin
            lfsr = nxt(lfsr);
            addr_pick: begin
                logic [7:0] a;
                logic [15:0] d;
                a = (lfsr[7:2] == 6'h00) ? lfsr[15:8] : 8'h2c + lfsr[1:0];
                d = lfsr[31:16];
                // Random traffic keeps to what software is asked to do
                if (mapped(a) && !a[1]) begin
                    if (m[{1'b1, a[0]}][1:0] == 2'b10 && d[4:0] == 5'h00)
                        d[0] = 1'b1;
                    wr(a, m[a[1:0]] | 16'h0080);
                end
                if (mapped(a) && a[1]) begin
                    if (d[1:0] == 2'b10 && m[{1'b0, a[0]}][4:0] == 5'h00)
                        d[1] = 1'b0;
                    if (d[1:0] != 2'b01)
                        d[6] = 1'b0;
                end
                wr(a, d);
                chk_ch(0);
                chk_ch(1);
                rd(a);
            end
        end
        $display("test random access done");
        do_reset();
        $display("test second reset done");
        stop_test();
    end
endmodule
